// *** rtl/rxm_core.sv ***
// Receiver mode control, data cleanup and shift clock recovery
//
// The address map and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/10ps

// Notes on behaviour
// - All edge checks passing enters receiving mode and drives data pin.
// - Receiving mode persists until host explicitly returns to polling or, with noise gate set, until the stream ends.
// - Demodulator resampled on extended tick; edges land on tick multiples.
// - Minimum spacing between output data edges suppresses spikes.
// - Data output low time capped by a maximum hold time.
// - After stream ends, stay active; pin high or noise per gate bit.
// - Host low beyond limit resets both configuration registers.
// - Sleep via data pin yields one single sync pulse.
// - Off command is host low, then three fixed intervals, then sleep (startup if polling pin low).
// - Polling pin low then high plus fixed delay resumes polling at sleep.
// - Polling pin low leaves sleep after delay; sleep word, count ignored.
// - Sleep word at maximum sleeps while polling pin stays high.
// - Clock recovery accepts only single or double interval spacings.
// - Single interval window reuses bit-check lower and upper counts.
// - Double window is sum minus/plus half difference, rounded up.
// - Clock starts after double start bit; fixed delay after pin edge.
// - Violation stops clock, reruns check in receive, restarts on start bit.
// - Zero check count or forced mode: clock after double start bit.
// - Bi-phase streams get clock pulse at end of bit period.
// - Clock pulse only after sensed pin equals driven level, plus delay.
// - Noise gate set: end of stream enters check, pin high.
// - Baud band scales extended tick by eight, four, two, one.
// - Check spacing below lower or reaching upper count aborts to sleep before first receive.
module rxm_core
  import rxm_pkg::*;
#(
  parameter int BASE_DIV_P = BASE_DIV
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        demod_in,
  input  wire logic        data_pin_in,
  output logic             data_pin_out,
  output logic             data_pin_oe,
  input  wire logic        polling_n_in,
  output logic             data_clk_out,
  output logic             rx_mode
);

  if (BASE_DIV_P < 1 || BASE_DIV_P > 256) begin
    $error("BASE_DIV_P must lie in 1..256");
  end

  localparam logic [7:0] DIV_LAST = 8'(BASE_DIV_P - 1);

  typedef struct packed {
    rxm_state_t  st;
    logic [1:0]  dm_s;
    logic [1:0]  dp_s;
    logic [1:0]  po_s;
    logic [7:0]  div;
    logic [2:0]  xdiv;
    logic        btk;
    logic        xtk;
    logic        dem_r;
    logic        idat;
    logic        lmax_hit;
    logic [6:0]  sp;
    logic [7:0]  lowc;
    logic [4:0]  ok;
    logic        phase;
    logic        clk_run;
    logic        clk_pend;
    logic [7:0]  cdly;
    logic        clk_out;
    logic [7:0]  chi;
    logic [15:0] tmr;
    logic [11:0] hlow;
    logic [15:0] plow;
    logic [1:0]  offph;
    logic [1:0]  guard;
    logic        rx_lat;
    logic [1:0]  band;
    logic [1:0]  nchk;
    logic        noise_gate;
    logic [4:0]  sleepw;
    logic        biphase;
    logic [5:0]  lmin;
    logic [5:0]  lmax;
    logic [31:0] prdata;
  } rxm_regs_t;

  localparam rxm_regs_t RST = '{
    st: ST_SLEEP, dm_s: 2'h3, dp_s: 2'h3, po_s: 2'h3, dem_r: 1'b1,
    idat: 1'b1, band: DEF_BAND, nchk: DEF_NCHK, noise_gate: DEF_NG,
    sleepw: DEF_SLEEP, biphase: DEF_BIPH, lmin: DEF_LMIN,
    lmax: DEF_LMAX, default: '0};

  rxm_regs_t q;
  rxm_regs_t next_q;

  logic       drive_low;
  logic       forced;
  logic [6:0] lo2;
  logic [6:0] hi2;

  always_comb begin
    drive_low = ((q.st == ST_RECEIVE) && !q.idat) ||
                ((q.st == ST_OFFCMD) && (q.offph == OFF_SYNC));
    forced    = !q.po_s[1];
    lo2 = 7'(q.lmin) + 7'(q.lmax) - 7'((q.lmax - q.lmin) >> 1);
    hi2 = 7'(q.lmin) + 7'(q.lmax)
        + 7'((7'(q.lmax) - 7'(q.lmin) + 7'h01) >> 1);
  end

  always_comb begin
    logic [2:0] xlast;
    logic       target;
    logic       flip;
    logic       edge_e;
    logic [6:0] meas;
    logic       is_t;
    logic       is_2t;
    logic [4:0] need;
    logic       hl_sense;
    logic       pol_rise;
    logic       pin_match;
    logic       emit;
    logic       wr;
    next_q    = q;
    xlast     = 3'(4'h8 >> q.band) - 3'h1;
    target    = 1'b1;
    flip      = 1'b0;
    edge_e    = 1'b0;
    meas      = '0;
    is_t      = 1'b0;
    is_2t     = 1'b0;
    need      = forced ? 5'h00 : 5'(q.nchk) * 5'h06;
    hl_sense  = 1'b0;
    pol_rise  = q.po_s[1] && (q.plow >= ON2_TK);
    pin_match = (q.dp_s[1] == !drive_low);
    emit      = 1'b0;
    wr        = psel && penable && pwrite;

    // Synchronisers
    next_q.dm_s = {q.dm_s[0], demod_in};
    next_q.dp_s = {q.dp_s[0], data_pin_in};
    next_q.po_s = {q.po_s[0], polling_n_in};

    // Base and extended tick
    next_q.btk = (q.div == DIV_LAST);
    next_q.div = (q.div == DIV_LAST) ? 8'h00 : q.div + 8'h01;
    next_q.xtk = 1'b0;
    if (q.btk) begin
      next_q.xdiv = (q.xdiv >= xlast) ? 3'h0 : q.xdiv + 3'h1;
      next_q.xtk  = (q.xdiv >= xlast);
    end

    // Resampling, spike suppression, low limit
    if (q.xtk) begin
      next_q.dem_r = q.dm_s[1];
      target = q.lmax_hit ? 1'b1 : q.dem_r;
      flip   = (target != q.idat) && (q.sp >= DATA_MIN_XT);
      edge_e = flip;
      meas   = (q.sp == SP_MAX) ? SP_MAX : q.sp + 7'h01;
      next_q.sp = flip ? 7'h00 : meas;
      if (flip) begin
        next_q.idat = !q.idat;
      end
      if (q.idat || flip) begin
        next_q.lowc = 8'h00;
      end else if (q.lowc != 8'hff) begin
        next_q.lowc = q.lowc + 8'h01;
      end
      if (!q.idat && (q.lowc >= DATA_LMAX_XT)) begin
        next_q.lmax_hit = 1'b1;
      end else if (q.dem_r) begin
        next_q.lmax_hit = 1'b0;
      end
    end
    is_t  = (meas >= q.lmin) && (meas < q.lmax);
    is_2t = (7'(meas) >= lo2) && (7'(meas) < hi2);

    // Polling pin low time
    if (q.po_s[1]) begin
      next_q.plow = '0;
    end else if (q.btk && (q.plow != 16'hffff)) begin
      next_q.plow = q.plow + 16'h0001;
    end

    // Host low detection on the open drain pin
    next_q.guard = drive_low ? 2'h3 : ((q.guard != 2'h0) ? q.guard - 2'h1
                                                         : 2'h0);
    hl_sense = !q.dp_s[1] && !drive_low && (q.guard == 2'h0);
    if (hl_sense) begin
      if (q.xtk && (q.hlow != 12'hfff)) begin
        next_q.hlow = q.hlow + 12'h001;
      end
    end else begin
      next_q.hlow = '0;
    end

    // Timer in base ticks
    if (q.btk && (q.tmr != 16'hffff)) begin
      next_q.tmr = q.tmr + 16'h0001;
    end

    unique case (q.st)
      ST_SLEEP: begin
        if (forced && (q.plow >= ON1_TK)) begin
          next_q.st = ST_STARTUP;
        end else if (!forced && (q.sleepw != SLEEP_PERM) &&
                     (q.tmr >= 16'(q.sleepw) * SLEEP_UNIT)) begin
          next_q.st = ST_STARTUP;
        end
      end
      ST_STARTUP: begin
        if (q.tmr >= STARTUP_TK) begin
          next_q.st = ST_CHECK;
          next_q.ok = '0;
        end
      end
      ST_CHECK: begin
        if (need == 5'h00 || q.ok >= need) begin
          next_q.st     = ST_RECEIVE;
          next_q.rx_lat = 1'b1;
          next_q.ok     = need;
        end else if (edge_e && is_t) begin
          next_q.ok = q.ok + 5'h01;
        end else if ((edge_e && !is_t) ||
                     (q.xtk && !edge_e && meas >= q.lmax)) begin
          next_q.ok = '0;
          if (!q.rx_lat && !forced) begin
            next_q.st = ST_SLEEP;
          end
        end
      end
      ST_RECEIVE: begin
        if (edge_e && (is_t || is_2t)) begin
          if (q.ok < need) begin
            next_q.ok = q.ok + 5'h01;
          end
          if (!q.clk_run) begin
            if (is_2t && q.ok >= need) begin
              next_q.clk_run = 1'b1;
              next_q.phase   = 1'b0;
              emit           = 1'b1;
            end
          end else if (is_2t && q.phase) begin
            next_q.clk_run = 1'b0;
            next_q.ok      = '0;
          end else if (is_2t) begin
            emit = 1'b1;
          end else begin
            next_q.phase = !q.phase;
            emit         = q.phase;
          end
        end else if ((edge_e || (q.xtk && 7'(meas) >= hi2)) &&
                     (q.clk_run || q.ok != 5'h00)) begin
          next_q.clk_run = 1'b0;
          next_q.ok      = '0;
          if (q.noise_gate) begin
            next_q.st = ST_CHECK;
          end
        end
      end
      ST_OFFCMD: begin
        unique case (q.offph)
          OFF_WAIT: if (q.tmr >= OFF2_TK) begin
            next_q.offph = OFF_SYNC;
            next_q.tmr   = '0;
          end
          OFF_SYNC: if (q.tmr >= SYNC_TK) begin
            next_q.offph = OFF_TAIL;
            next_q.tmr   = '0;
          end
          default: if (q.tmr >= OFF10_TK) begin
            next_q.st = forced ? ST_STARTUP : ST_SLEEP;
          end
        endcase
      end
      ST_PDELAY: begin
        if (q.tmr >= ON3_TK) begin
          next_q.st = ST_SLEEP;
        end
      end
      default: next_q.st = ST_SLEEP;
    endcase

    // Explicit return to polling
    if (q.st == ST_CHECK || q.st == ST_RECEIVE) begin
      if (pol_rise) begin
        next_q.st = ST_PDELAY;
      end else if (!hl_sense && q.hlow >= OFF_MIN_XT) begin
        next_q.st    = ST_OFFCMD;
        next_q.offph = OFF_WAIT;
      end
    end
    if (next_q.st != q.st) begin
      next_q.tmr = '0;
      if (next_q.st != ST_RECEIVE) begin
        next_q.clk_run = 1'b0;
      end
      if (next_q.st == ST_SLEEP || next_q.st == ST_PDELAY) begin
        next_q.rx_lat = 1'b0;
      end
    end

    // Clock pulse after the pin settles
    if (emit) begin
      next_q.clk_pend = 1'b1;
      next_q.cdly     = '0;
    end else if (q.clk_pend && pin_match) begin
      if (q.cdly >= DLY2_CYC - 8'h01) begin
        next_q.clk_pend = 1'b0;
        next_q.clk_out  = 1'b1;
        next_q.chi      = '0;
      end else begin
        next_q.cdly = q.cdly + 8'h01;
      end
    end
    if (q.clk_out) begin
      next_q.chi = q.chi + 8'h01;
      if (q.chi >= CLKHI_CYC - 8'h01) begin
        next_q.clk_out = 1'b0;
      end
    end

    // APB register access
    if (wr && paddr == ADDR_CONFIG) begin
      next_q.band       = pwdata[CFG_BAND_LSB +: 2];
      next_q.nchk       = pwdata[CFG_NCHK_LSB +: 2];
      next_q.noise_gate = pwdata[CFG_NG_BIT];
      next_q.sleepw     = pwdata[CFG_SLEEP_LSB +: 5];
      next_q.biphase    = pwdata[CFG_BIPH_BIT];
    end
    if (wr && paddr == ADDR_LIMIT) begin
      next_q.lmin = pwdata[LIM_MIN_LSB +: 6];
      next_q.lmax = pwdata[LIM_MAX_LSB +: 6];
    end
    if (!hl_sense && q.hlow >= CFG_RST_XT) begin
      next_q.band       = DEF_BAND;
      next_q.nchk       = DEF_NCHK;
      next_q.noise_gate = DEF_NG;
      next_q.sleepw     = DEF_SLEEP;
      next_q.biphase    = DEF_BIPH;
      next_q.lmin       = DEF_LMIN;
      next_q.lmax       = DEF_LMAX;
    end
    if (psel && !penable) begin
      next_q.prdata = '0;
      unique case (paddr)
        ADDR_CONFIG: begin
          next_q.prdata[CFG_BAND_LSB +: 2]  = q.band;
          next_q.prdata[CFG_NCHK_LSB +: 2]  = q.nchk;
          next_q.prdata[CFG_NG_BIT]         = q.noise_gate;
          next_q.prdata[CFG_SLEEP_LSB +: 5] = q.sleepw;
          next_q.prdata[CFG_BIPH_BIT]       = q.biphase;
        end
        ADDR_LIMIT: begin
          next_q.prdata[LIM_MIN_LSB +: 6] = q.lmin;
          next_q.prdata[LIM_MAX_LSB +: 6] = q.lmax;
        end
        ADDR_STATUS: begin
          next_q.prdata[ST_STATE_LSB +: 6] = q.st;
          next_q.prdata[ST_CLK_BIT]        = q.clk_run;
          next_q.prdata[ST_DATA_BIT]       = q.idat;
          next_q.prdata[ST_LAT_BIT]        = q.rx_lat;
        end
        default: next_q.prdata = '0;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= RST;
    end else begin
      q <= next_q;
    end
  end

  // Outputs
  always_comb begin
    prdata       = q.prdata;
    pready       = 1'b1;
    pslverr      = psel && penable && (paddr != ADDR_CONFIG) &&
                   (paddr != ADDR_LIMIT) && (paddr != ADDR_STATUS);
    data_pin_out = 1'b0;
    data_pin_oe  = drive_low;
    data_clk_out = q.clk_out;
    rx_mode      = (q.st == ST_RECEIVE);
  end

endmodule

// *** rtl/rxm_pkg.sv ***
// Constants, field layout and state codes of the receiver back end
package rxm_pkg;

  // Clock and base tick
  localparam int CLK_NS      = 10;
  localparam int TICK_NS     = 1000;
  localparam int BASE_DIV    = TICK_NS / CLK_NS;

  // Fixed delays, in ns, and as counts of base ticks
  localparam int T_STARTUP_NS = 1_000_000;
  localparam int T_ON1_NS     = 20_000;
  localparam int T_ON2_NS     = 20_000;
  localparam int T_ON3_NS     = 20_000;
  localparam int T_OFF2_NS    = 500_000;
  localparam int T_SYNC_NS    = 200_000;
  localparam int T_OFF10_NS   = 200_000;
  localparam logic [15:0] STARTUP_TK = 16'(T_STARTUP_NS / TICK_NS);
  localparam logic [15:0] ON1_TK     = 16'(T_ON1_NS / TICK_NS);
  localparam logic [15:0] ON2_TK     = 16'(T_ON2_NS / TICK_NS);
  localparam logic [15:0] ON3_TK     = 16'(T_ON3_NS / TICK_NS);
  localparam logic [15:0] OFF2_TK    = 16'(T_OFF2_NS / TICK_NS);
  localparam logic [15:0] SYNC_TK    = 16'(T_SYNC_NS / TICK_NS);
  localparam logic [15:0] OFF10_TK   = 16'(T_OFF10_NS / TICK_NS);
  localparam logic [15:0] SLEEP_UNIT = 16'h0400;
  localparam logic [4:0]  SLEEP_PERM = 5'h1f;

  // Clock pulse delay and width, in ns and in pclk cycles
  localparam int T_DLY2_NS   = 1_000;
  localparam int T_CLKHI_NS  = 2_000;
  localparam logic [7:0] DLY2_CYC  = 8'((T_DLY2_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [7:0] CLKHI_CYC = 8'((T_CLKHI_NS + CLK_NS - 1) / CLK_NS);

  // Limits counted in extended ticks
  localparam logic [5:0]  DATA_MIN_XT  = 6'h06;
  localparam logic [7:0]  DATA_LMAX_XT = 8'hc8;
  localparam logic [11:0] OFF_MIN_XT   = 12'h100;
  localparam logic [11:0] CFG_RST_XT   = 12'hfa0;
  localparam logic [6:0]  SP_MAX       = 7'h7f;

  // APB register map
  localparam logic [11:0] ADDR_CONFIG = 12'h000;
  localparam logic [11:0] ADDR_LIMIT  = 12'h004;
  localparam logic [11:0] ADDR_STATUS = 12'h008;

  // operation_config_reg fields
  localparam int CFG_BAND_LSB  = 0;
  localparam int CFG_NCHK_LSB  = 2;
  localparam int CFG_NG_BIT    = 4;
  localparam int CFG_SLEEP_LSB = 5;
  localparam int CFG_BIPH_BIT  = 10;
  localparam logic [1:0] DEF_BAND  = 2'h0;
  localparam logic [1:0] DEF_NCHK  = 2'h1;
  localparam logic       DEF_NG    = 1'b1;
  localparam logic [4:0] DEF_SLEEP = 5'h06;
  localparam logic       DEF_BIPH  = 1'b0;

  // Window register fields
  localparam int LIM_MIN_LSB = 0;
  localparam int LIM_MAX_LSB = 8;
  localparam logic [5:0] DEF_LMIN = 6'h15;
  localparam logic [5:0] DEF_LMAX = 6'h29;

  // Status register fields
  localparam int ST_STATE_LSB = 0;
  localparam int ST_CLK_BIT   = 8;
  localparam int ST_DATA_BIT  = 9;
  localparam int ST_LAT_BIT   = 10;

  // Off command phases
  localparam logic [1:0] OFF_WAIT = 2'h0;
  localparam logic [1:0] OFF_SYNC = 2'h1;
  localparam logic [1:0] OFF_TAIL = 2'h2;

  typedef enum logic [5:0] {
    ST_SLEEP   = 6'b00_0001,
    ST_STARTUP = 6'b00_0010,
    ST_CHECK   = 6'b00_0100,
    ST_RECEIVE = 6'b00_1000,
    ST_OFFCMD  = 6'b01_0000,
    ST_PDELAY  = 6'b10_0000
  } rxm_state_t;

endpackage

// *** test/rxm_core_properties.sv ***
// Port level checks of the receiver back end
`timescale 1ns/10ps
module rxm_core_properties
  import rxm_pkg::*;
#(
  parameter int BASE_DIV_P = BASE_DIV
) (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic [11:0] paddr,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        data_pin_in,
  input wire logic        data_pin_out,
  input wire logic        data_pin_oe,
  input wire logic        data_clk_out,
  input wire logic        rx_mode
);
  localparam int MIN_C = 6 * BASE_DIV_P;
  localparam int LOW_C = 1604 * BASE_DIV_P;
  localparam int SYN_C = int'(SYNC_TK) * BASE_DIV_P;
  logic        oe_d;
  logic [15:0] run;
  logic [8:0]  clk_run;
  logic        mapped;
  logic        oe_fell;
  assign mapped = paddr == ADDR_CONFIG || paddr == ADDR_LIMIT ||
                  paddr == ADDR_STATUS;
  assign oe_fell = oe_d && !data_pin_oe;
  // Length of the current data_pin_oe run and clock pulse
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      oe_d <= 1'b0;
      run <= 16'hffff;
      clk_run <= 9'h000;
    end else begin
      oe_d <= data_pin_oe;
      if (data_pin_oe != oe_d) begin
        run <= 16'h0001;
      end else if (run != 16'hffff) begin
        run <= run + 16'h0001;
      end
      clk_run <= data_clk_out ? clk_run + 9'h001 : 9'h000;
    end
  end
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  sequence s_clk_start;
    $rose(data_clk_out);
  endsequence
  property p_edge_gap;
    (data_pin_oe != oe_d) && rx_mode && $past(rx_mode) |-> run >= MIN_C;
  endproperty
  a_edge_gap: assert property (p_edge_gap) else $error("edge gap short");
  property p_low_max;
    oe_fell && rx_mode && $past(rx_mode) |-> run <= LOW_C;
  endproperty
  a_low_max: assert property (p_low_max) else $error("low too long");
  property p_sync;
    oe_fell && !rx_mode && !$past(rx_mode, 8) |->
      run >= SYN_C - 2 * BASE_DIV_P && run <= SYN_C + 2 * BASE_DIV_P;
  endproperty
  a_sync: assert property (p_sync) else $error("sync width");
  property p_clk_mode;
    s_clk_start |-> rx_mode;
  endproperty
  a_clk_mode: assert property (p_clk_mode) else $error("clk outside rx");
  property p_clk_level;
    s_clk_start |-> data_pin_in == !data_pin_oe;
  endproperty
  a_clk_level: assert property (p_clk_level) else $error("clk level");
  property p_clk_width;
    $fell(data_clk_out) && rx_mode |-> clk_run == 9'(CLKHI_CYC);
  endproperty
  a_clk_width: assert property (p_clk_width) else $error("clk width");
  property p_drain;
    data_pin_out == 1'b0;
  endproperty
  a_drain: assert property (p_drain) else $error("pin driven high");
  property p_err;
    psel && penable && !mapped |-> pslverr && pready;
  endproperty
  a_err: assert property (p_err) else $error("no slave error");
  property p_ok;
    psel && penable && mapped |-> !pslverr && pready;
  endproperty
  a_ok: assert property (p_ok) else $error("false slave error");
endmodule

bind rxm_core rxm_core_properties #(.BASE_DIV_P(BASE_DIV_P)) u_props (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .paddr(paddr), .pready(pready), .pslverr(pslverr),
  .data_pin_in(data_pin_in), .data_pin_out(data_pin_out),
  .data_pin_oe(data_pin_oe), .data_clk_out(data_clk_out),
  .rx_mode(rx_mode));

// *** test/rxm_host.sv ***
// Host controller model on the data and polling pins
`timescale 1ns/10ps
module rxm_host (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        off_go,
  input  wire logic [15:0] off_cyc,
  input  wire logic        poll_go,
  input  wire logic        dev_oe,
  output logic             host_oe,
  output logic             polling_n,
  output logic             data_line
);
  logic [15:0] cnt;
  assign data_line = !(host_oe || dev_oe);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= 16'h0000;
      host_oe <= 1'b0;
      polling_n <= 1'b1;
    end else begin
      polling_n <= !poll_go;
      if (off_go) begin
        cnt <= off_cyc;
      end else if (cnt != 16'h0000) begin
        cnt <= cnt - 16'h0001;
      end
      host_oe <= off_go || cnt > 16'h0001;
    end
  end
endmodule

// *** test/testbench.sv ***
// Self-checking bench for the receiver back end
`timescale 1ns/10ps
module testbench
  import rxm_pkg::*;
;
  localparam int B = 8;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic        demod_in = 1'b1;
  logic        off_go = 1'b0;
  logic [15:0] off_cyc = 16'h0000;
  logic        poll_go = 1'b0;
  logic [31:0] prdata, rd;
  logic        pready, pslverr, er, data_pin_out, data_pin_oe;
  logic        data_line, host_oe, polling_n, data_clk_out, rx_mode;
  logic        clk_d = 1'b0;
  logic        oe_d = 1'b0;
  int          err_total = 0;
  int          samples_checked = 0;
  int          clk_cnt = 0;
  int          oe_cnt = 0;

  always #5 pclk = ~pclk;

  rxm_core #(.BASE_DIV_P(B)) dut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .demod_in(demod_in), .data_pin_in(data_line),
    .data_pin_out(data_pin_out), .data_pin_oe(data_pin_oe),
    .polling_n_in(polling_n), .data_clk_out(data_clk_out),
    .rx_mode(rx_mode));
  rxm_host u_host (.pclk(pclk), .presetn(presetn), .off_go(off_go),
    .off_cyc(off_cyc), .poll_go(poll_go), .dev_oe(data_pin_oe),
    .host_oe(host_oe), .polling_n(polling_n), .data_line(data_line));

  always @(posedge pclk) begin
    clk_d <= data_clk_out;
    oe_d <= data_pin_oe;
    if (data_clk_out === 1'b1 && clk_d === 1'b0) clk_cnt++;
    if (data_pin_oe === 1'b1 && oe_d === 1'b0) oe_cnt++;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic edges(input int n, input int gap);
    repeat (n) begin
      repeat (gap * B) @(posedge pclk);
      demod_in <= !demod_in;
    end
  endtask

  task automatic wait_state(input logic [5:0] s, input int lim);
    for (int i = 0; i < lim; i++) begin
      apb(1'b0, ADDR_STATUS, 32'h0);
      if (rd[5:0] === s) break;
      edges(1, 30);
    end
  endtask

  task automatic t_regs();
    apb(1'b0, ADDR_CONFIG, 32'h0);
    chk(rd, 32'h0000_00d4);
    apb(1'b0, ADDR_LIMIT, 32'h0);
    chk(rd, 32'h0000_2915);
    apb(1'b1, ADDR_STATUS, 32'hffff_ffff);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk(32'(rd[5:0]), 32'h1);
    apb(1'b1, 12'h00c, 32'h0000_0003);
    chk(32'(er), 32'h1);
    apb(1'b0, 12'h00c, 32'h0);
    chk(rd, 32'h0);
    apb(1'b1, ADDR_CONFIG, 32'h0000_00d7);
    apb(1'b0, ADDR_CONFIG, 32'h0);
    chk(rd, 32'h0000_00d7);
    $display("test regs done");
  endtask

  task automatic t_force();
    int c0;
    poll_go <= 1'b1;
    repeat (30 * B) @(posedge pclk);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk(32'(rd[5:0]), 32'h2);
    wait_state(6'h08, 60);
    chk(32'(rd[5:0]), 32'h8);
    c0 = clk_cnt;
    edges(8, 30);
    chk(32'(clk_cnt - c0), 32'h0);
    edges(1, 60);
    edges(2, 30);
    edges(1, 60);
    edges(2, 30);
    repeat (400) @(posedge pclk);
    chk(32'(clk_cnt - c0), 32'h4);
    chk(32'(data_pin_oe), 32'(!demod_in));
    apb(1'b1, ADDR_CONFIG, 32'h0000_00c7);
    if (demod_in) edges(1, 30);
    repeat (250 * B) @(posedge pclk);
    chk(32'(data_pin_oe), 32'h0);
    chk(32'(rx_mode), 32'h1);
    apb(1'b1, ADDR_CONFIG, 32'h0000_0037);
    poll_go <= 1'b0;
    repeat (2 * B) @(posedge pclk);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk(32'(rd[5:0]), 32'h20);
    repeat (25 * B) @(posedge pclk);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk(32'(rd[5:0]), 32'h1);
    $display("test force done");
  endtask

  task automatic t_check();
    wait_state(6'h04, 100);
    chk(32'(rd[5:0]), 32'h4);
    edges(1, 10);
    repeat (4 * B) @(posedge pclk);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk(32'(rd[5:0]), 32'h1);
    wait_state(6'h08, 200);
    chk(32'(rx_mode), 32'h1);
    edges(1, 60);
    edges(1, 30);
    edges(1, 60);
    repeat (4 * B) @(posedge pclk);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk(32'(rd[8:0]), 32'h008);
    edges(1, 30);
    repeat (100 * B) @(posedge pclk);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk(32'(rd[5:0]), 32'h4);
    chk(32'(data_pin_oe), 32'h0);
    wait_state(6'h08, 20);
    chk(32'(rd[5:0]), 32'h8);
    edges(1, 60);
    repeat (4 * B) @(posedge pclk);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk(32'(rd[8]), 32'h1);
    $display("test check done");
  endtask

  task automatic t_off();
    int c0;
    apb(1'b1, ADDR_CONFIG, 32'h0000_03f7);
    if (!demod_in) edges(1, 30);
    repeat (30 * B) @(posedge pclk);
    c0 = oe_cnt;
    off_cyc <= 16'(300 * B);
    off_go <= 1'b1;
    @(posedge pclk);
    off_go <= 1'b0;
    repeat (1300 * B) @(posedge pclk);
    chk(32'(oe_cnt - c0), 32'h1);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk(32'(rd[5:0]), 32'h1);
    repeat (500 * B) @(posedge pclk);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk(32'(rd[5:0]), 32'h1);
    $display("test off done");
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_force();
    t_check();
    t_off();
    finish_test();
  end

  initial begin
    repeat (95000) @(posedge pclk);
    err_total++;
    finish_test();
  end
endmodule
